// *** design/adc_seq_defs.vh ***
// Timing and field constants for the recirculating converter sequencer.
`ifndef ADC_SEQ_DEFS_VH
`define ADC_SEQ_DEFS_VH
`define CLK_HZ          8000000
`define SLOW_CLK_HZ     1000000
`define NIBBLE_COUNT    5
`define NIBBLE_BITS     6
`define TRACK_US        100
`define TRACK_CYCLES    ((`TRACK_US * (`CLK_HZ / 1000000)))
`define AZ_US           200
`define AZ_CYCLES       ((`AZ_US * (`CLK_HZ / 1000000)))
`define BIT_CYCLES      16
`define STORE_CYCLES    64
`define PRECHARGE_CYCLES 32
`define WDOG_MS         1500
`define WDOG_CYCLES     ((`WDOG_MS * (`CLK_HZ / 1000)))
`define REBOOT_US       100
`define REBOOT_CYCLES   ((`REBOOT_US * (`CLK_HZ / 1000000)))
`define MODE_IDLE       2'h0
`define MODE_AUTOZERO   2'h1
`define MODE_COMPARE    2'h2
`define MODE_STORE      2'h3
`endif

// *** design/host_watchdog.v ***
// Watchdog that pulls the host reset low after select inactivity.
`timescale 1ns/10ps
`include "adc_seq_defs.vh"
module host_watchdog #(
	parameter integer TIMEOUT_CYCLES = `WDOG_CYCLES,
	parameter integer PULSE_CYCLES   = `REBOOT_CYCLES
) (
	input  wire clk_sys,
	input  wire rst,
	input  wire kick,
	output reg  host_reboot_n
);

	reg [31:0] count_r;

	always @(posedge clk_sys) begin
		if (rst) begin
			count_r       <= 32'h0;
			host_reboot_n <= 1'b1;
		end else if (!host_reboot_n) begin
			// While the host sits in reset it cannot read, so the pulse ends on time, not on activity.
			if (count_r >= PULSE_CYCLES - 1) begin
				count_r       <= 32'h0;
				host_reboot_n <= 1'b1;
			end else begin
				count_r <= count_r + 32'h1;
			end
		end else if (kick) begin
			count_r <= 32'h0;
		end else if (count_r >= TIMEOUT_CYCLES - 1) begin
			count_r       <= 32'h0;
			host_reboot_n <= 1'b0;
		end else begin
			count_r <= count_r + 32'h1;
		end
	end

endmodule // host_watchdog

// *** design/adc_sequencer.v ***
// Timing and data control for the recirculating-remainder converter.
`timescale 1ns/10ps
`include "adc_seq_defs.vh"
module adc_sequencer #(
	parameter integer WDOG_TIMEOUT   = `WDOG_CYCLES,
	parameter integer REBOOT_LEN     = `REBOOT_CYCLES,
	parameter integer TRACK_LEN      = `TRACK_CYCLES,
	parameter integer AZ_LEN         = `AZ_CYCLES,
	parameter integer BIT_LEN        = `BIT_CYCLES,
	parameter integer STORE_LEN      = `STORE_CYCLES,
	parameter integer PRECHARGE_LEN  = `PRECHARGE_CYCLES
) (
	input  wire       clk_sys,
	input  wire       rst,
	input  wire       conv_start_n,
	input  wire       result_select_n,
	input  wire       comparator_hi,
	input  wire       precharge_en,
	output reg  [5:0] nibble_bus,
	output reg  [5:0] ladder_sw,
	output reg  [1:0] amp_mode,
	output reg        store_sel,
	output reg        data_ready_n,
	output wire       host_reboot_n,
	output reg        clk_1mhz,
	output reg        precharge_ctl,
	output reg        hold_ctl,
	output reg        sample_phase_a,
	output reg        sample_phase_b,
	output reg        busy
);

	localparam [2:0] ST_IDLE   = 3'h0;
	localparam [2:0] ST_TRACK  = 3'h1;
	localparam [2:0] ST_AZ     = 3'h2;
	localparam [2:0] ST_CMP    = 3'h3;
	localparam [2:0] ST_STORE  = 3'h4;
	localparam [2:0] ST_PRECHG = 3'h5;

	localparam integer DIV_HALF = `CLK_HZ / `SLOW_CLK_HZ / 2;

	////////////////////////////////////////////////////////////////////////////////
	// Input synchronisers and edge detection.

	reg [1:0] start_sync_r;
	reg [1:0] sel_sync_r;
	reg [1:0] cmp_sync_r;
	reg [1:0] pre_sync_r;
	reg       start_prev_r;
	reg       sel_prev_r;
	wire      start_fall;
	wire      sel_fall;

	always @(posedge clk_sys) begin
		if (rst) begin
			start_sync_r <= 2'h3;
			sel_sync_r   <= 2'h3;
			cmp_sync_r   <= 2'h0;
			pre_sync_r   <= 2'h0;
			start_prev_r <= 1'b1;
			sel_prev_r   <= 1'b1;
		end else begin
			start_sync_r <= {start_sync_r[0], conv_start_n};
			sel_sync_r   <= {sel_sync_r[0], result_select_n};
			cmp_sync_r   <= {cmp_sync_r[0], comparator_hi};
			pre_sync_r   <= {pre_sync_r[0], precharge_en};
			start_prev_r <= start_sync_r[1];
			sel_prev_r   <= sel_sync_r[1];
		end
	end

	assign start_fall = start_prev_r & ~start_sync_r[1];
	assign sel_fall   = sel_prev_r & ~sel_sync_r[1];

	////////////////////////////////////////////////////////////////////////////////
	// Clock divider for the display controller.

	reg [2:0] div_r;

	always @(posedge clk_sys) begin
		if (rst) begin
			div_r    <= 3'h0;
			clk_1mhz <= 1'b0;
		end else if (div_r == DIV_HALF[2:0] - 3'h1) begin
			div_r    <= 3'h0;
			clk_1mhz <= ~clk_1mhz;
		end else begin
			div_r <= div_r + 3'h1;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Conversion sequencer.

	reg [2:0]  state_r;
	reg [15:0] tmr_r;
	reg [2:0]  bit_r;
	reg [2:0]  intv_r;
	reg [5:0]  nib_r [0:4];
	reg [2:0]  rd_ptr_r;
	integer    i;

	// Ladder value with the trial bit set.
	function [5:0] trial_mask;
		input [2:0] b;
		begin
			trial_mask = 6'h01 << b;
		end
	endfunction

	always @(posedge clk_sys) begin
		if (rst) begin
			state_r        <= ST_IDLE;
			tmr_r          <= 16'h0;
			bit_r          <= 3'h5;
			intv_r         <= 3'h0;
			ladder_sw      <= 6'h00;
			amp_mode       <= `MODE_IDLE;
			store_sel      <= 1'b0;
			data_ready_n   <= 1'b1;
			rd_ptr_r       <= 3'h0;
			nibble_bus     <= 6'h00;
			precharge_ctl  <= 1'b0;
			hold_ctl       <= 1'b0;
			sample_phase_a <= 1'b0;
			sample_phase_b <= 1'b0;
			busy           <= 1'b0;
			for (i = 0; i < 5; i = i + 1)
				nib_r[i] <= 6'h00;
		end else begin
			// A select falling edge hands out the next stored nibble.
			if (sel_fall && rd_ptr_r < `NIBBLE_COUNT) begin
				nibble_bus <= nib_r[rd_ptr_r];
				rd_ptr_r   <= rd_ptr_r + 3'h1;
				if (rd_ptr_r == `NIBBLE_COUNT - 1)
					data_ready_n <= 1'b1;
			end
			// A new start aborts whatever is running; the host owns the pacing.
			if (start_fall) begin
				state_r        <= ST_TRACK;
				tmr_r          <= 16'h0;
				data_ready_n   <= 1'b1;
				rd_ptr_r       <= 3'h0;
				intv_r         <= 3'h0;
				store_sel      <= 1'b0;
				ladder_sw      <= 6'h00;
				amp_mode       <= `MODE_IDLE;
				busy           <= 1'b1;
				sample_phase_a <= 1'b1;
				sample_phase_b <= 1'b1;
				hold_ctl       <= 1'b0;
				precharge_ctl  <= 1'b0;
			end else begin
				case (state_r)
				ST_IDLE: begin
					amp_mode <= `MODE_IDLE;
				end
				ST_TRACK: begin
					if (tmr_r == TRACK_LEN / 2)
						sample_phase_b <= 1'b0;
					if (tmr_r >= TRACK_LEN - 1) begin
						sample_phase_a <= 1'b0;
						hold_ctl       <= 1'b1;
						tmr_r          <= 16'h0;
						state_r        <= ST_AZ;
						amp_mode       <= `MODE_AUTOZERO;
					end else begin
						tmr_r <= tmr_r + 16'h1;
					end
				end
				ST_AZ: begin
					if (tmr_r >= AZ_LEN - 1) begin
						tmr_r     <= 16'h0;
						bit_r     <= 3'h5;
						ladder_sw <= trial_mask(3'h5);
						state_r   <= ST_CMP;
						amp_mode  <= `MODE_COMPARE;
					end else begin
						tmr_r <= tmr_r + 16'h1;
					end
				end
				ST_CMP: begin
					if (tmr_r >= BIT_LEN - 1) begin
						tmr_r <= 16'h0;
						// Comparator high means ladder exceeds input: reopen the trial bit.
						if (cmp_sync_r[1])
							ladder_sw <= ladder_sw & ~trial_mask(bit_r);
						if (bit_r == 3'h0) begin
							nib_r[intv_r] <= cmp_sync_r[1] ? (ladder_sw & ~trial_mask(bit_r))
							                               : ladder_sw;
							state_r  <= ST_STORE;
							amp_mode <= `MODE_STORE;
						end else begin
							bit_r     <= bit_r - 3'h1;
							ladder_sw <= (cmp_sync_r[1] ? (ladder_sw & ~trial_mask(bit_r)) : ladder_sw)
							             | trial_mask(bit_r - 3'h1);
						end
					end else begin
						tmr_r <= tmr_r + 16'h1;
					end
				end
				ST_STORE: begin
					if (tmr_r >= STORE_LEN - 1) begin
						tmr_r     <= 16'h0;
						store_sel <= ~store_sel;
						ladder_sw <= 6'h00;
						if (intv_r == `NIBBLE_COUNT - 1) begin
							data_ready_n <= 1'b0;
							rd_ptr_r     <= 3'h0;
							amp_mode     <= `MODE_IDLE;
							hold_ctl     <= 1'b0;
							busy         <= 1'b0;
							state_r      <= pre_sync_r[1] ? ST_PRECHG : ST_IDLE;
							precharge_ctl <= pre_sync_r[1];
						end else begin
							intv_r    <= intv_r + 3'h1;
							bit_r     <= 3'h5;
							ladder_sw <= trial_mask(3'h5);
							state_r   <= ST_CMP;
							amp_mode  <= `MODE_COMPARE;
						end
					end else begin
						tmr_r <= tmr_r + 16'h1;
					end
				end
				ST_PRECHG: begin
					if (tmr_r >= PRECHARGE_LEN - 1) begin
						tmr_r         <= 16'h0;
						precharge_ctl <= 1'b0;
						state_r       <= ST_IDLE;
					end else begin
						tmr_r <= tmr_r + 16'h1;
					end
				end
				default: begin
					state_r <= ST_IDLE;
				end
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Host watchdog.

	host_watchdog #(
		.TIMEOUT_CYCLES (WDOG_TIMEOUT),
		.PULSE_CYCLES   (REBOOT_LEN)
	) u_wdog (
		.clk_sys       (clk_sys),
		.rst           (rst),
		.kick          (sel_fall),
		.host_reboot_n (host_reboot_n)
	);

endmodule // adc_sequencer

// *** sim/adc_sequencer_sva.sv ***
// Port checker for the converter sequencer.
`timescale 1ns/10ps
module adc_seq_checker (
	input logic       clk_sys,
	input logic       rst,
	input logic       conv_start_n,
	input logic       result_select_n,
	input logic [5:0] nibble_bus,
	input logic [1:0] amp_mode,
	input logic       store_sel,
	input logic       data_ready_n,
	input logic       host_reboot_n,
	input logic       clk_1mhz,
	input logic       busy
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);
	AST_START_BUSY: assert property ($fell(conv_start_n) |-> ##[1:5] busy)
		else $error("busy did not follow a start");
	AST_START_RELEASE: assert property ($fell(conv_start_n) |-> ##[1:5] data_ready_n)
		else $error("ready not released by a start");
	AST_READY_AFTER_RUN: assert property ($fell(data_ready_n) |-> !busy)
		else $error("ready raised while converting");
	AST_STORE_AFTER_CMP: assert property ($rose(amp_mode == 2'h3) |-> $past(amp_mode) == 2'h2)
		else $error("store not after compare");
	AST_CMP_ORDER: assert property ($rose(amp_mode == 2'h2) |-> $past(amp_mode) inside {2'h1, 2'h3})
		else $error("compare in wrong order");
	AST_STORE_SWAP: assert property ($fell(amp_mode == 2'h3) |-> ##[0:1] $changed(store_sel))
		else $error("store element not swapped");
	AST_DIV8: assert property ($rose(clk_1mhz) |-> ##4 $fell(clk_1mhz))
		else $error("slow clock duty wrong");
	AST_REBOOT_LEN: assert property ($fell(host_reboot_n) |-> !host_reboot_n [*8] ##1 host_reboot_n)
		else $error("reboot pulse length wrong");
	AST_BUS_HOLD: assert property (result_select_n [*5] |-> $stable(nibble_bus))
		else $error("nibble bus moved without a read");
	C_READY: cover property ($fell(data_ready_n));
	C_READ: cover property ($fell(result_select_n) && !data_ready_n);
	C_REBOOT: cover property ($fell(host_reboot_n));
endmodule // adc_seq_checker
bind adc_sequencer adc_seq_checker chk_i (.clk_sys, .rst, .conv_start_n, .result_select_n, .nibble_bus,
	.amp_mode, .store_sel, .data_ready_n, .host_reboot_n, .clk_1mhz, .busy);

// *** sim/analog_far_end.sv ***
// Analog front end model: comparator judging the ladder against each remainder.
`timescale 1ns/10ps
module analog_far_end (
	input  logic        clk_sys,
	input  logic        rst,
	input  logic [5:0]  ladder_sw,
	input  logic [1:0]  amp_mode,
	input  logic [29:0] vin,
	output logic        comparator_hi
);
	integer idx;
	logic [1:0] mode_q;
	logic [29:0] level;
	// Each store scales the residual by sixteen, so each later interval resolves four more input bits.
	always @(posedge clk_sys) begin
		mode_q <= amp_mode;
		if (rst || amp_mode == 2'h1)
			idx <= 0;
		else if (mode_q == 2'h3 && amp_mode != 2'h3)
			idx <= idx + 1;
	end
	// The ladder is an integer, so comparing with the floor of the residual gives the same answer.
	always @* begin
		level = (idx == 0) ? (vin >> 24) : ((vin & ((30'h1 << (28 - 4 * idx)) - 30'h1)) >> (24 - 4 * idx));
		comparator_hi = {24'h0, ladder_sw} > level;
	end
endmodule // analog_far_end

// *** sim/tb.sv ***
// Self-checking bench for the converter sequencer.
`timescale 1ns/10ps
module tb;
	logic clk_sys, rst, conv_start_n, result_select_n, comparator_hi, precharge_en;
	logic [5:0] nibble_bus, ladder_sw;
	logic [1:0] amp_mode;
	logic store_sel, data_ready_n, host_reboot_n, clk_1mhz, busy;
	logic [29:0] vin;
	logic precharge_ctl, hold_ctl, sample_phase_a, sample_phase_b;
	logic [5:0] exp_q[$];
	logic [5:0] last_exp;
	integer n_errors = 0, n_tests = 0, r, k, i, acc;
	localparam integer WDOG = 1000;
	localparam integer REBOOT = 8;
	// Track is long enough that both phases still stand when the start task returns.
	adc_sequencer #(.WDOG_TIMEOUT(WDOG), .REBOOT_LEN(REBOOT), .TRACK_LEN(16), .AZ_LEN(8)) uut (.clk_sys(clk_sys),
		.rst(rst), .conv_start_n(conv_start_n), .result_select_n(result_select_n), .comparator_hi(comparator_hi),
		.precharge_en(precharge_en), .nibble_bus(nibble_bus), .ladder_sw(ladder_sw), .amp_mode(amp_mode),
		.store_sel(store_sel), .data_ready_n(data_ready_n), .host_reboot_n(host_reboot_n), .clk_1mhz(clk_1mhz),
		.precharge_ctl(precharge_ctl), .hold_ctl(hold_ctl), .sample_phase_a(sample_phase_a),
		.sample_phase_b(sample_phase_b), .busy(busy));
	analog_far_end fe (.clk_sys(clk_sys), .rst(rst), .ladder_sw(ladder_sw), .amp_mode(amp_mode), .vin(vin),
		.comparator_hi(comparator_hi));
	////////////////////////////////////////////////////////////////////////////
	task cyc(input integer n);
		repeat (n) @(posedge clk_sys);
		#2;
	endtask
	task chk(input string what, input logic [5:0] exp, input logic [5:0] got);
		n_tests++;
		if (got !== exp) begin
			n_errors++;
			$display("unexpected %s: expected %h seen %h", what, exp, got);
		end
	endtask
	task chk_word(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_tests++;
		if (got !== exp) begin
			n_errors++;
			$display("unexpected %s: expected %0d seen %0d", what, exp, got);
		end
	endtask
	// Nibble n of a sample: the first holds six bits, each later one the next four after a gain of sixteen.
	function automatic logic [5:0] nib_exp(input logic [29:0] v, input integer n);
		if (n == 0)
			return v >> 24;
		return (v & ((30'h1 << (28 - 4 * n)) - 30'h1)) >> (24 - 4 * n);
	endfunction
	task load_model;
		integer j;
		exp_q.delete();
		for (j = 0; j < 5; j++)
			exp_q.push_back(nib_exp(vin, j));
	endtask
	// Reads past the fifth leave the bus on the last nibble.
	task read_chk;
		pulse_read;
		if (exp_q.size() > 0)
			last_exp = exp_q.pop_front();
		chk("nibble", last_exp, nibble_bus);
	endtask
	task wait_ready;
		for (i = 0; i < 2000 && data_ready_n !== 1'b0; i++)
			cyc(1);
		chk("ready low", 6'h0, {5'h0, data_ready_n});
	endtask
	task pulse_start;
		conv_start_n = 0;
		cyc(5);
		conv_start_n = 1;
		cyc(5);
	endtask
	// Low and high phases both exceed the pin synchroniser depth.
	task pulse_read;
		result_select_n = 0;
		cyc(5);
		result_select_n = 1;
		cyc(5);
	endtask
	task wrap_up;
		$display("tests %0d errors %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////
	initial begin
		clk_sys = 0;
		forever #20 clk_sys = ~clk_sys;
	end
	initial begin
		#(40 * 20000);
		n_errors++;
		wrap_up;
	end
	initial begin
		rst = 1; conv_start_n = 1; result_select_n = 1; precharge_en = 0; vin = 0;
		i = $urandom(30);
		cyc(6);
		rst = 0;
		chk("ready idle", 6'h1, {5'h0, data_ready_n});
		chk("reboot idle", 6'h1, {5'h0, host_reboot_n});
		chk("bus idle", 6'h0, nibble_bus);
		for (r = 0; r < 4; r++) begin
			vin = $urandom;
			precharge_en = $urandom;
			pulse_start;
			chk("track phases", 6'h3, {4'h0, sample_phase_a, sample_phase_b});
			chk("busy", 6'h1, {5'h0, busy});
			// A second start mid-run must abort and restart cleanly.
			if (r == 2) begin
				cyc(300);
				chk("hold in store", 6'h1, {5'h0, hold_ctl});
				chk("mode in store", 6'h3, {4'h0, amp_mode});
				chk("second store element", 6'h1, {5'h0, store_sel});
				vin = $urandom;
				pulse_start;
			end
			wait_ready;
			chk("precharge", {5'h0, precharge_en}, {5'h0, precharge_ctl});
			chk("hold released", 6'h0, {5'h0, hold_ctl});
			// A start after a partial read must release ready and begin the next sample at its first nibble.
			if (r == 1) begin
				load_model;
				read_chk;
				read_chk;
				vin = $urandom;
				pulse_start;
				chk("ready after restart", 6'h1, {5'h0, data_ready_n});
				wait_ready;
			end
			load_model;
			acc = 0;
			for (k = 0; k < 6; k++) begin
				read_chk;
				if (k < 5)
					acc = acc * 16 + nibble_bus;
			end
			chk_word("sample value", vin >> 8, acc);
			chk("ready released", 6'h1, {5'h0, data_ready_n});
		end
		for (i = 0; i < WDOG + 100 && host_reboot_n !== 1'b0; i++)
			cyc(1);
		// The last select fall is seen three edges late and the read task returns ten edges after it.
		chk_word("watchdog delay", WDOG - 7, i);
		for (k = 0; k < 20 && host_reboot_n === 1'b0; k++)
			cyc(1);
		chk("reboot length", REBOOT[5:0], k[5:0]);
		wrap_up;
	end
endmodule // tb
